// ==== verilog/io_ports.sv ====
// Three mode-shared 8-bit I/O ports with an AXI4-Lite register slave.
// Operation
// R1: Each port data register is eight bits, bit n holding the output value for pin n.
// R2: A data register read returns the latch for output pins and the live pin level for input pins.
// R3: The data-bus port data register clears to zero on reset and hardware standby.
// R4: The low-address port data register clears to zero on reset and hardware standby.
// R5: In expanded modes the data-bus port is the external data bus and its direction register is ignored.
// R6: In single-chip mode a pin drives its data bit when its direction bit is 1 and is an input when 0.
// R7: Direction registers are write-only; reads complete without error and return all ones.
// R8: Direction registers clear to zero on reset and hardware standby, making every pin an input.
// R9: Software standby leaves direction registers alone and output pins keep driving their data.
// R10: In expanded modes the low-address port outputs A7-A0 with its direction forced to 1 and locked.
// R11: In ROM-using expanded modes a high-address pin outputs its address bit when direction is 1, else input.
// R12: In ROM-less expanded modes the high-address direction is held at 1, ignores writes, and outputs A15-A8.
// R13: The high-address port has per-pin pull-ups that software can switch.
// R14: The high-address port data register clears to zero on reset and hardware standby.
// R15: A high-address pull-up is on only with direction 0 and data 1, and off in reset, standby and ROM-less modes; the code ignores software standby.
// R16: The data-bus port direction register clears to zero on reset and hardware standby.
// R17: The mode input, stable after reset, selects single-chip, ROM-using or ROM-less expanded behaviour.
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
`include "io_ports_cfg.svh"
module io_ports (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [2:0] mode_pins,
  input wire logic hw_standby,
  input wire logic sw_standby,
  input wire logic [15:0] ext_addr,
  input wire logic [7:0] ext_wdata,
  input wire logic ext_write,
  output logic [7:0] ext_rdata,
  input wire logic [15:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [15:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] data_bus_pin_i,
  output logic [7:0] data_bus_pin_o,
  output logic [7:0] data_bus_pin_oe,
  input wire logic [7:0] low_addr_pin_i,
  output logic [7:0] low_addr_pin_o,
  output logic [7:0] low_addr_pin_oe,
  input wire logic [7:0] high_addr_pin_i,
  output logic [7:0] high_addr_pin_o,
  output logic [7:0] high_addr_pin_oe,
  output logic [7:0] high_addr_pullup_en
);
  import io_ports_pkg::*;

  pin_mode_t pin_mode_q;
  logic mode_taken_q;
  port_byte_t data_bus_port_direction_q;
  port_byte_t data_bus_port_data_q;
  port_byte_t low_addr_port_direction_q;
  port_byte_t low_addr_port_data_q;
  port_byte_t high_addr_port_direction_q;
  port_byte_t high_addr_port_data_q;
  logic [15:0] awaddr_q;
  logic aw_held_q;
  logic [7:0] wdata_q;
  logic wstrb0_q;
  logic w_held_q;
  logic wr_fire;
  logic init_regs;
  logic expanded;
  logic norom;
  port_byte_t db_dir_eff;
  port_byte_t la_dir_eff;
  port_byte_t ha_dir_eff;
  port_byte_t db_rd;
  port_byte_t la_rd;
  port_byte_t ha_rd;
  port_byte_t ha_force;
  logic [7:0] rd_byte;
  logic rd_hit;
  logic wr_hit;
  logic [15:0] wr_index;
  logic [15:0] rd_index;
  logic wr_en;
  logic wr_db_dir;
  logic wr_db_dat;
  logic wr_la_dir;
  logic wr_la_dat;
  logic wr_ha_dir;
  logic wr_ha_dat;
  pin_mode_t pin_mode_d;
  port_byte_t high_addr_pullup_d;
  logic [1:0] bresp_d;

  // Registers clear on reset and on hardware standby; software standby changes nothing.
  assign init_regs = !aresetn || hw_standby; // [R8] [R9]

  // Strap decode; codes outside the expanded set fall back to single-chip so a stray strap never claims the bus.
  always_comb begin
    case (mode_pins) // [R17]
      `MODE_EXP_NOROM_A, `MODE_EXP_NOROM_B: pin_mode_d = PIN_MODE_EXP_NOROM;
      `MODE_EXP_ROM_A, `MODE_EXP_ROM_B: pin_mode_d = PIN_MODE_EXP_ROM;
      default: pin_mode_d = PIN_MODE_SINGLE;
    endcase
  end

  // The mode straps are caught once after reset is released, so the pins may change later.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_taken_q <= 1'b0;
      pin_mode_q <= PIN_MODE_SINGLE;
    end else if (!mode_taken_q) begin
      mode_taken_q <= 1'b1;
      pin_mode_q <= pin_mode_d; // [R17]
    end
  end

  assign expanded = mode_taken_q && (pin_mode_q != PIN_MODE_SINGLE);
  assign norom = mode_taken_q && (pin_mode_q == PIN_MODE_EXP_NOROM);

  // The 16-bit bus carries only the low 14 index bits; the top two are implied, so the map aliases.
  assign wr_index = {`REG_INDEX_PAGE, awaddr_q[15:`REG_INDEX_LSB]};
  assign rd_index = {`REG_INDEX_PAGE, s_axi_araddr[15:`REG_INDEX_LSB]};

  // One write strobe per register; a byte write needs lane 0, and an empty lane still answers OKAY.
  assign wr_en = wr_fire && wstrb0_q;
  assign wr_db_dir = wr_en && (wr_index == `DATA_BUS_PORT_DIRECTION_OFF);
  assign wr_db_dat = wr_en && (wr_index == `DATA_BUS_PORT_DATA_OFF);
  assign wr_la_dir = wr_en && (wr_index == `LOW_ADDR_PORT_DIRECTION_OFF) && !expanded; // [R10]
  assign wr_la_dat = wr_en && (wr_index == `LOW_ADDR_PORT_DATA_OFF);
  assign wr_ha_dir = wr_en && (wr_index == `HIGH_ADDR_PORT_DIRECTION_OFF) && !norom; // [R12]
  assign wr_ha_dat = wr_en && (wr_index == `HIGH_ADDR_PORT_DATA_OFF);

  // Write channel capture: address and data are taken in either order, one write at a time.
  assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready = !w_held_q && !s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 16'h0000;
      wdata_q <= 8'h00;
      wstrb0_q <= 1'b0;
    end else if (wr_fire) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata[7:0];
        wstrb0_q <= s_axi_wstrb[0];
      end
    end
  end

  assign wr_fire = aw_held_q && w_held_q;

  // Unmapped indices still complete, with a decode error, so a stray write cannot hang the master.
  assign bresp_d = wr_hit ? `AXI_RESP_OKAY : `AXI_RESP_DECERR;

  // Write response follows one cycle after both halves are held.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `AXI_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= bresp_d;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Offsets are not word aligned, so the printed offset is an index and the byte address is four times it.
  always_comb begin
    wr_hit = 1'b1;
    case (wr_index)
      `DATA_BUS_PORT_DIRECTION_OFF, `LOW_ADDR_PORT_DIRECTION_OFF, `DATA_BUS_PORT_DATA_OFF,
      `LOW_ADDR_PORT_DATA_OFF, `HIGH_ADDR_PORT_DIRECTION_OFF, `HIGH_ADDR_PORT_DATA_OFF: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // Data-bus port registers; a byte write needs lane 0.
  always_ff @(posedge aclk) begin
    if (init_regs) begin
      data_bus_port_direction_q <= `PORT_RESET_VALUE; // [R16]
      data_bus_port_data_q <= `PORT_RESET_VALUE; // [R3]
    end else begin
      if (wr_db_dir) begin
        data_bus_port_direction_q <= wdata_q;
      end
      if (wr_db_dat) begin
        data_bus_port_data_q <= wdata_q; // [R1]
      end
    end
  end

  // Low-address port registers; direction is locked while expanded.
  always_ff @(posedge aclk) begin
    if (init_regs) begin
      low_addr_port_direction_q <= `PORT_RESET_VALUE; // [R8]
      low_addr_port_data_q <= `PORT_RESET_VALUE; // [R4]
    end else begin
      if (wr_la_dir) begin
        low_addr_port_direction_q <= wdata_q; // [R10]
      end
      if (wr_la_dat) begin
        low_addr_port_data_q <= wdata_q; // [R1]
      end
    end
  end

  // High-address port registers; direction ignores writes in the ROM-less modes.
  always_ff @(posedge aclk) begin
    if (init_regs) begin
      high_addr_port_direction_q <= `PORT_RESET_VALUE; // [R8]
      high_addr_port_data_q <= `PORT_RESET_VALUE; // [R14]
    end else begin
      if (wr_ha_dir) begin
        high_addr_port_direction_q <= wdata_q; // [R12]
      end
      if (wr_ha_dat) begin
        high_addr_port_data_q <= wdata_q; // [R1] [R13]
      end
    end
  end

  // Effective directions: address pins forced to all outputs where the mode owns them; the expanded data bus follows ext_write.
  assign db_dir_eff = expanded ? (ext_write ? `ALL_OUTPUT : `PORT_RESET_VALUE) : data_bus_port_direction_q; // [R5]
  assign la_dir_eff = expanded ? `ALL_OUTPUT : low_addr_port_direction_q; // [R10]
  assign ha_dir_eff = norom ? `ALL_OUTPUT : high_addr_port_direction_q; // [R11] [R12]
  // Modes set pin enables through the effective direction only, so readback always follows the same select as drive.
  assign ha_force = `PORT_RESET_VALUE;

  // The data-bus port carries the external data bus in expanded modes.
  port_pin_mux u_data_bus (
    .dir(db_dir_eff),
    .dat(data_bus_port_data_q),
    .alt_val(ext_wdata),
    .alt_sel(expanded ? `ALL_OUTPUT : `PORT_RESET_VALUE), // [R5]
    .force_oe(ha_force),
    .pin_i(data_bus_pin_i),
    .pin_o(data_bus_pin_o),
    .pin_oe(data_bus_pin_oe),
    .rd_val(db_rd)
  ); // [R6] [R2]

  // The low-address port carries address bits 7 to 0 in expanded modes.
  port_pin_mux u_low_addr (
    .dir(la_dir_eff),
    .dat(low_addr_port_data_q),
    .alt_val(ext_addr[7:0]),
    .alt_sel(expanded ? `ALL_OUTPUT : `PORT_RESET_VALUE), // [R10]
    .force_oe(ha_force),
    .pin_i(low_addr_pin_i),
    .pin_o(low_addr_pin_o),
    .pin_oe(low_addr_pin_oe),
    .rd_val(la_rd)
  ); // [R6] [R2]

  // The high-address port carries address bits 15 to 8 on every output pin while expanded.
  port_pin_mux u_high_addr (
    .dir(ha_dir_eff),
    .dat(high_addr_port_data_q),
    .alt_val(ext_addr[15:8]),
    .alt_sel(expanded ? `ALL_OUTPUT : `PORT_RESET_VALUE), // [R11]
    .force_oe(ha_force),
    .pin_i(high_addr_pin_i),
    .pin_o(high_addr_pin_o),
    .pin_oe(high_addr_pin_oe),
    .rd_val(ha_rd)
  ); // [R6] [R2]

  // Pull-ups follow input direction with data one; off in reset, hardware standby and ROM-less modes.
  always_comb begin
    if (init_regs || norom) begin
      high_addr_pullup_d = `PORT_RESET_VALUE; // [R15]
    end else begin
      high_addr_pullup_d = ~ha_dir_eff & high_addr_port_data_q; // [R13] [R15]
    end
  end

  // Registered so the pad control never glitches while a direction or data write settles.
  always_ff @(posedge aclk) begin
    high_addr_pullup_en <= high_addr_pullup_d;
  end

  // The external bus sees the data-bus pins as read data.
  // One flop keeps the pad input off the bus path; the level arrives one cycle late.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_rdata <= `PORT_RESET_VALUE;
    end else begin
      ext_rdata <= data_bus_pin_i;
    end
  end

  // Read decode; direction registers read as all ones without error.
  always_comb begin
    rd_byte = `PORT_RESET_VALUE;
    rd_hit = 1'b1;
    case (rd_index)
      `DATA_BUS_PORT_DIRECTION_OFF, `LOW_ADDR_PORT_DIRECTION_OFF,
      `HIGH_ADDR_PORT_DIRECTION_OFF: rd_byte = `DIRECTION_READ_VALUE; // [R7]
      `DATA_BUS_PORT_DATA_OFF: rd_byte = db_rd; // [R2]
      `LOW_ADDR_PORT_DATA_OFF: rd_byte = la_rd; // [R2]
      `HIGH_ADDR_PORT_DATA_OFF: rd_byte = ha_rd; // [R2]
      default: rd_hit = 1'b0;
    endcase
  end

  // Read channel: one read at a time, answered the cycle after the address is taken.
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `AXI_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rd_byte};
      s_axi_rresp <= rd_hit ? `AXI_RESP_OKAY : `AXI_RESP_DECERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== verilog/io_ports_cfg.svh ====
// Register offsets, reset values and mode codes for the mode-shared I/O ports.
`ifndef IO_PORTS_CFG_SVH
`define IO_PORTS_CFG_SVH
`define DATA_BUS_PORT_DIRECTION_OFF 16'hfe84
`define LOW_ADDR_PORT_DIRECTION_OFF 16'hfe85
`define DATA_BUS_PORT_DATA_OFF 16'hfe86
`define LOW_ADDR_PORT_DATA_OFF 16'hfe87
`define HIGH_ADDR_PORT_DIRECTION_OFF 16'hfe88
`define HIGH_ADDR_PORT_DATA_OFF 16'hfe8a
`define PORT_RESET_VALUE 8'h00
`define DIRECTION_READ_VALUE 8'hff
`define ALL_OUTPUT 8'hff
`define MODE_EXP_NOROM_A 3'h1
`define MODE_EXP_ROM_A 3'h2
`define MODE_EXP_NOROM_B 3'h3
`define MODE_EXP_ROM_B 3'h4
`define MODE_SINGLE_CHIP 3'h7
`define AXI_RESP_OKAY 2'h0
`define AXI_RESP_DECERR 2'h3
`define REG_INDEX_LSB 2
`define REG_INDEX_PAGE 2'h3
`endif

// ==== verilog/io_ports_pkg.sv ====
// Types shared by the mode-shared I/O port block.
package io_ports_pkg;
  typedef enum logic [1:0] {
    PIN_MODE_SINGLE,
    PIN_MODE_EXP_ROM,
    PIN_MODE_EXP_NOROM
  } pin_mode_t;
  typedef logic [7:0] port_byte_t;
endpackage

// ==== verilog/port_pin_mux.sv ====
// One 8-bit port pin multiplexer: drive enable, output value and readback per pin.
`timescale 1ns/1ns
`default_nettype none
module port_pin_mux (
  input wire logic [7:0] dir,
  input wire logic [7:0] dat,
  input wire logic [7:0] alt_val,
  input wire logic [7:0] alt_sel,
  input wire logic [7:0] force_oe,
  input wire logic [7:0] pin_i,
  output logic [7:0] pin_o,
  output logic [7:0] pin_oe,
  output logic [7:0] rd_val
);
  // Per pin: an alternate function wins over the latch; direction steers drive and readback.
  genvar n;
  for (n = 0; n < 8; n++) begin : g_pin
    assign pin_oe[n] = dir[n] | force_oe[n];
    assign pin_o[n] = alt_sel[n] ? alt_val[n] : dat[n];
    assign rd_val[n] = dir[n] ? dat[n] : pin_i[n];
  end
endmodule
`default_nettype wire

// ==== verification/io_ports_asserts.sv ====
// Checker for pin routing, pull-ups and register reads of the I/O port block.
`timescale 1ns/1ns
`default_nettype none
module io_ports_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [2:0] mode_pins,
  input wire logic hw_standby,
  input wire logic [15:0] ext_addr,
  input wire logic [7:0] ext_wdata,
  input wire logic ext_write,
  input wire logic [7:0] ext_rdata,
  input wire logic [15:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [7:0] data_bus_pin_i,
  input wire logic [7:0] data_bus_pin_o,
  input wire logic [7:0] data_bus_pin_oe,
  input wire logic [7:0] low_addr_pin_o,
  input wire logic [7:0] low_addr_pin_oe,
  input wire logic [7:0] high_addr_pin_o,
  input wire logic [7:0] high_addr_pin_oe,
  input wire logic [7:0] high_addr_pullup_en
);
  logic taken_q, rl_q, ex_q, sc;
  logic [15:0] ra_q;
  logic [7:0] db_rd;
  // The strap is taken once, on the first edge after reset, so classes stay fixed.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      taken_q <= 1'b0;
      rl_q <= 1'b0;
      ex_q <= 1'b0;
    end else if (!taken_q) begin
      taken_q <= 1'b1;
      rl_q <= mode_pins == 3'h1 || mode_pins == 3'h3;
      ex_q <= mode_pins inside {3'h1, 3'h2, 3'h3, 3'h4};
    end
  end
  // The read address is kept until the answer, since arready stays low meanwhile.
  always_ff @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) begin
      ra_q <= s_axi_araddr;
    end
  end
  // Single-chip class and the level a data-bus port data read must return.
  assign sc = taken_q && !ex_q;
  assign db_rd = (data_bus_pin_o & data_bus_pin_oe) | (data_bus_pin_i & ~data_bus_pin_oe);
  default clocking dc @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_db_exp; ex_q |-> data_bus_pin_oe == {8{ext_write}} && ((data_bus_pin_o ^ ext_wdata) & data_bus_pin_oe) == 8'h00; endproperty
  a_db_exp: assert property (p_db_exp) else $error("data bus pins wrong");
  property p_lo_exp; ex_q |-> low_addr_pin_oe == 8'hff && low_addr_pin_o == ext_addr[7:0]; endproperty
  a_lo_exp: assert property (p_lo_exp) else $error("low address pins wrong");
  property p_hi_rl; rl_q |-> high_addr_pin_oe == 8'hff && high_addr_pin_o == ext_addr[15:8]; endproperty
  a_hi_rl: assert property (p_hi_rl) else $error("high address pins wrong");
  property p_hi_rom; ex_q && !rl_q |-> ((high_addr_pin_o ^ ext_addr[15:8]) & high_addr_pin_oe) == 8'h00; endproperty
  a_hi_rom: assert property (p_hi_rom) else $error("high address bits wrong");
  property p_pu_rl; rl_q |-> high_addr_pullup_en == 8'h00; endproperty
  a_pu_rl: assert property (p_pu_rl) else $error("pull-up on without rom");
  property p_pu_hsb; hw_standby |=> high_addr_pullup_en == 8'h00; endproperty
  a_pu_hsb: assert property (p_pu_hsb) else $error("pull-up on in standby");
  property p_dir_rd; s_axi_rvalid && ra_q inside {16'hfa10, 16'hfa14, 16'hfa20} |-> s_axi_rdata == 32'h000000ff; endproperty
  a_dir_rd: assert property (p_dir_rd) else $error("direction read not all ones");
  property p_rd_pin; sc && s_axi_arvalid && s_axi_arready && s_axi_araddr == 16'hfa18 |=> s_axi_rdata[7:0] == $past(db_rd); endproperty
  a_rd_pin: assert property (p_rd_pin) else $error("data read mixes latch and pins wrongly");
  property p_ext_rd; $past(aresetn) |-> ext_rdata == $past(data_bus_pin_i); endproperty
  a_ext_rd: assert property (p_ext_rd) else $error("external read data stale");
endmodule
bind io_ports io_ports_asserts chk (.*);
`default_nettype wire

// ==== verification/pin_world.sv ====
// Far side of one port: pin levels seen by the block, with optional pull-ups.
`timescale 1ns/1ns
`default_nettype none
module pin_world (
  input wire logic clk,
  input wire logic [7:0] o,
  input wire logic [7:0] oe,
  input wire logic [7:0] pu,
  output logic [7:0] pin_i
);
  logic [7:0] pat_q = 8'h5a;
  // Undriven lines wander each cycle, so a stale level is never read back by luck.
  always_ff @(posedge clk) begin
    pat_q <= pat_q + 8'h6b;
  end
  assign pin_i = (o & oe) | (~oe & (pu | pat_q));
endmodule
`default_nettype wire

// ==== verification/tb.sv ====
// Self-checking bench for the mode-shared I/O ports.
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic aclk = 1'b0, aresetn = 1'b0, hw_standby = 1'b0, sw_standby = 1'b0, ext_write = 1'b0;
  logic [2:0] mode_pins = 3'h7, s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [15:0] ext_addr = 16'h0000, s_axi_awaddr = 16'h0000, s_axi_araddr = 16'h0000;
  logic [7:0] ext_wdata = 8'h00;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [7:0] ext_rdata, data_bus_pin_i, data_bus_pin_o, data_bus_pin_oe, low_addr_pin_i, low_addr_pin_o;
  logic [7:0] low_addr_pin_oe, high_addr_pin_i, high_addr_pin_o, high_addr_pin_oe, high_addr_pullup_en;
  logic [7:0] dd, ld, hd, dv, lv, hv;
  logic [2:0] modes [6] = '{3'h7, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5};
  logic sc, rl;
  logic [23:0] r;
  logic [17:0] e;
  logic [17:0] qr[$];
  logic [1:0] qb[$];
  int fails = 0;
  int total_checks = 0;
  int seed = 49413;
  io_ports uut (.*);
  pin_world db_w (.clk(aclk), .o(data_bus_pin_o), .oe(data_bus_pin_oe), .pu(8'h00), .pin_i(data_bus_pin_i));
  pin_world lo_w (.clk(aclk), .o(low_addr_pin_o), .oe(low_addr_pin_oe), .pu(8'h00), .pin_i(low_addr_pin_i));
  pin_world hi_w (.clk(aclk), .o(high_addr_pin_o), .oe(high_addr_pin_oe), .pu(high_addr_pullup_en), .pin_i(high_addr_pin_i));
  // Free-running clock at 20 MHz.
  initial forever #25 aclk = ~aclk;
  task chk(input logic [33:0] s, input logic [33:0] x);
    total_checks++;
    if (s !== x) begin
      fails++;
      $display("ERROR %0t seen %h want %h", $time, s, x);
    end
  endtask
  task test_done;
    if (fails == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // One AXI4-Lite transfer; bits of p are the raised requests, dropped as each is taken.
  task xf(input bit w, input logic [15:0] a, input logic [7:0] d, input logic [7:0] mk, input logic [1:0] rs);
    int n;
    logic [4:0] p;
    logic [4:0] h;
    n = 0;
    p = w ? 5'h07 : 5'h18;
    if (w) qb.push_back(rs);
    else qr.push_back({rs, mk, d});
    @(posedge aclk);
    s_axi_awaddr <= {a[13:0], 2'b00};
    s_axi_araddr <= {a[13:0], 2'b00};
    s_axi_wdata <= {24'h000000, d};
    {s_axi_rready, s_axi_arvalid, s_axi_bready, s_axi_wvalid, s_axi_awvalid} <= p;
    while (p != 5'h00 && n < 100) begin
      @(negedge aclk);
      h = p & {s_axi_rvalid, s_axi_arready, s_axi_bvalid, s_axi_wready, s_axi_awready};
      @(posedge aclk);
      p = p & ~h;
      {s_axi_rready, s_axi_arvalid, s_axi_bready, s_axi_wvalid, s_axi_awvalid} <= p;
      n++;
    end
    if (p != 5'h00) begin
      fails++;
      $display("ERROR %0t bus timeout", $time);
      test_done();
    end
  endtask
  // Data reads: only bits whose effective direction is output show the latch.
  task rd3;
    xf(0, 16'hfe86, dv, sc ? dd : 8'h00, 2'h0);
    xf(0, 16'hfe87, lv, sc ? ld : 8'hff, 2'h0);
    xf(0, 16'hfe8a, hv, rl ? 8'hff : hd, 2'h0);
  endtask
  // Pin enables and driven values of all three ports, plus the pull-ups.
  task pc;
    logic [7:0] edb, elo, ehi;
    @(negedge aclk);
    edb = sc ? dd : {8{ext_write}};
    elo = sc ? ld : 8'hff;
    ehi = rl ? 8'hff : hd;
    chk({data_bus_pin_oe, data_bus_pin_o & edb}, {edb, (sc ? dv : ext_wdata) & edb});
    chk({low_addr_pin_oe, low_addr_pin_o & elo}, {elo, (sc ? lv : ext_addr[7:0]) & elo});
    chk({high_addr_pin_oe, high_addr_pin_o & ehi}, {ehi, (sc ? hv : ext_addr[15:8]) & ehi});
    chk(high_addr_pullup_en, rl ? 8'h00 : ~hd & hv);
  endtask
  task rst(input logic [2:0] md);
    @(posedge aclk);
    aresetn <= 1'b0;
    mode_pins <= md;
    rl = md == 3'h1 || md == 3'h3;
    sc = !(md inside {3'h1, 3'h2, 3'h3, 3'h4});
    {dd, ld, hd, dv, lv, hv} = 48'h0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    {ext_write, ext_wdata, ext_addr} <= 25'($random(seed));
    repeat (2) @(posedge aclk);
  endtask
  // Oldest note against each accepted answer; mid-cycle sampling avoids edge races.
  always @(negedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      e = qr.pop_front();
      chk({s_axi_rresp, s_axi_rdata[31:8], s_axi_rdata[7:0] & e[15:8]}, {e[17:16], 24'h0, e[7:0] & e[15:8]});
    end
    if (s_axi_bvalid && s_axi_bready) chk(s_axi_bresp, qb.pop_front());
  end
  // Each strap mode in turn: directions, data, reads, both standby kinds.
  initial begin
    for (int i = 0; i < 6; i++) begin
      rst(modes[i]);
      r = 24'($random(seed));
      xf(1, 16'hfe84, r[7:0], 8'h00, 2'h0);
      xf(1, 16'hfe85, r[15:8], 8'h00, 2'h0);
      xf(1, 16'hfe88, r[23:16], 8'h00, 2'h0);
      dd = r[7:0];
      if (sc) ld = r[15:8];
      if (!rl) hd = r[23:16];
      rd3();
      r = 24'($random(seed));
      xf(1, 16'hfe86, r[7:0], 8'h00, 2'h0);
      xf(1, 16'hfe87, r[15:8], 8'h00, 2'h0);
      xf(1, 16'hfe8a, r[23:16], 8'h00, 2'h0);
      {hv, lv, dv} = r;
      rd3();
      xf(0, 16'hfe84, 8'hff, 8'hff, 2'h0);
      xf(0, 16'hfe85, 8'hff, 8'hff, 2'h0);
      xf(0, 16'hfe88, 8'hff, 8'hff, 2'h0);
      xf(0, 16'hfe89, 8'h00, 8'hff, 2'h3);
      xf(1, 16'hfe89, 8'h5a, 8'h00, 2'h3);
      pc();
      @(posedge aclk);
      sw_standby <= 1'b1;
      {ext_write, ext_wdata, ext_addr} <= 25'($random(seed));
      repeat (3) @(posedge aclk);
      pc();
      @(posedge aclk);
      sw_standby <= 1'b0;
      hw_standby <= 1'b1;
      repeat (2) @(posedge aclk);
      hw_standby <= 1'b0;
      {dd, ld, hd, dv, lv, hv} = 48'h0;
      pc();
      rd3();
    end
    test_done();
  end
endmodule
`default_nettype wire
